// File: core/rts_defines.svh
// register offsets, bit positions, codes and timing of the transmit sequencer
// assumes one 100 MHz digital clock
`ifndef RTS_DEFINES_SVH
`define RTS_DEFINES_SVH
`define RTS_A_CHIP 5'h00
`define RTS_A_PROTO 5'h01
`define RTS_A_TYPEB 5'h02
`define RTS_A_HBR 5'h03
`define RTS_A_PULSE 5'h06
`define RTS_A_TMR 5'h07
`define RTS_A_MOD 5'h09
`define RTS_A_RIO 5'h0b
`define RTS_A_IRQ 5'h0c
`define RTS_A_FCNT 5'h1c
`define RTS_A_LENH 5'h1d
`define RTS_A_LENL 5'h1e
`define RTS_A_FIFO 5'h1f
`define RTS_C_RESET 8'h0f
`define RTS_C_TX 8'h11
`define RTS_C_TX_TMR 8'h12
`define RTS_B_FULLPWR 4
`define RTS_B_DIRECT 6
`define RTS_B_EXTMOD 6
`define RTS_B_ANALOG 3
`define RTS_B_EXTPA 6
`define RTS_B_TXDONE 7
`define RTS_B_FLVL 5
`define RTS_B_NOSOF 7
`define RTS_B_NOEOF 6
`define RTS_B_EGT 5
`define RTS_B_SEPRATE 7
`define RTS_B_EVENPAR 6
`define RTS_FAM_A 3'h2
`define RTS_FAM_B 3'h3
`define RTS_DEPTH_OOK 3'h7
`define RTS_DEPTH_B 3'h1
`define RTS_DEPTH_V 3'h0
`define RTS_PRESET 8'h00
`define RTS_CRC_A 16'h6363
`define RTS_CRC_B 16'hffff
`define RTS_CRC_POLY 16'h8408
`define RTS_CLK_PS 10000
`define RTS_PULSE_UNIT_PS 73700
`define RTS_ETU_NS 9440
`define RTS_PULSE_A_NS 2950
`define RTS_TMR_UNIT_NS 1000
`endif

// File: core/rts_pkg.sv
// types shared by the transmit sequencer
// assumes the defines header is on the include path
package rts_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_ARMED, ST_SOF, ST_BITS, ST_GAP, ST_EOF
   } rts_st_t;
   // software visible registers
   typedef struct packed {
      logic [7:0] chip, proto, typeb, hbr, pulse, tmr, modc, rio;
      logic [7:0] irq, lenh, lenl;
   } rts_regs_t;
   // complete state of the sequencer
   typedef struct packed {
      rts_regs_t rg;
      rts_st_t st;
      logic [11:0] bytes_left; // whole bytes still to fetch
      logic part;              // trailing partial byte pending
      logic [1:0] crc_step;    // crc bytes still to send
      logic [8:0] sh;          // bits of the unit on air
      logic [3:0] nbits;       // bits left in that unit
      logic par_on;            // unit ends in a parity bit
      logic crc_on;            // unit feeds the crc
      logic [15:0] crc;
      logic [15:0] bcnt;       // cycle within the bit
      logic [15:0] tmr_cnt;    // launch delay left
      logic lvl_prev;
      logic mod, ext_mod, mod_ook, half, analog, rx_ext, irq_o, busy;
      logic [2:0] depth;
      logic [7:0] rdata;
      logic s1, s2;            // pin synchroniser
   } rts_state_t;
endpackage

// File: core/rts_tx_seq.sv
// transmit sequencer: registers, framing, pulse shaping, refill flags
// assumes one clock and a host on the register port
`timescale 1ns/1ns
`include "rts_defines.svh"

// byte buffer between the host writes and the serialiser
module rts_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready,
   output logic [AW:0] count
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp, rp;
      logic [AW:0] cnt;
      logic space; // registered so the ready seen outside is a flop
   } rts_fst_t;
   rts_fst_t f, fn;
   logic push, pop;

   assign push = in_valid && f.space;
   assign pop = out_ready && (f.cnt != '0);
   assign in_ready = f.space;
   assign out_valid = (f.cnt != '0);
   assign out_data = f.mem[f.rp];
   assign count = f.cnt;

   // pointer and count update; flush drops everything held
   always_comb begin
      fn = f;
      if (push) begin
         fn.mem[f.wp] = in_data;
         fn.wp = (f.wp == AW'(DEPTH - 1)) ? '0 : f.wp + 1'b1;
      end
      if (pop) begin
         fn.rp = (f.rp == AW'(DEPTH - 1)) ? '0 : f.rp + 1'b1;
      end
      fn.cnt = f.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         fn.wp = '0;
         fn.rp = '0;
         fn.cnt = '0;
      end
      fn.space = (fn.cnt != (AW+1)'(DEPTH));
   end

   // state register
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         f <= '0;
         f.space <= 1'b1;
      end else begin
         f <= fn;
      end
   end
endmodule

// transmit sequencer top
module rts_tx_seq #(
   parameter int DEPTH = 8,
   parameter int LOW_WM = 2,
   parameter int CW = $clog2(DEPTH) + 1
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic ext_mod_pin,
   output logic [7:0] reg_rdata,
   output logic wr_ready,
   output logic mod_out,
   output logic ext_pa_mod,
   output logic mod_type_ook,
   output logic [2:0] mod_depth,
   output logic half_power,
   output logic mod_type_analog,
   output logic rx_ext_subcarrier,
   output logic irq,
   output logic tx_busy
);
   rts_pkg::rts_state_t r, n;
   logic f_valid, f_pop, f_push, f_flush;
   logic [7:0] f_data;
   logic [CW-1:0] f_cnt;
   logic adv, sel, lvl, bend, m, fam_a, fam_b;
   logic [7:0] setb, clr;
   logic [15:0] bc, pc;

   // clock counts of the printed times
   function automatic logic [15:0] ns2cyc(input int ns);
      return 16'((ns * 1000 + `RTS_CLK_PS - 1) / `RTS_CLK_PS);
   endfunction

   // bit period; a separate tx rate overrides the protocol rate
   function automatic logic [15:0] bit_cyc(input logic [7:0] p,
                                           input logic [7:0] h);
      logic [1:0] rate;
      rate = h[`RTS_B_SEPRATE] ? h[1:0] : p[1:0];
      return ns2cyc(`RTS_ETU_NS) >> rate;
   endfunction

   // modulation pulse length in clocks
   function automatic logic [15:0] pulse_cyc(input logic [7:0] pl,
                                             input logic [7:0] p);
      if (pl != 8'h00)
         return 16'((int'(pl) * `RTS_PULSE_UNIT_PS + `RTS_CLK_PS - 1)
                    / `RTS_CLK_PS);
      else if (p[4:2] == `RTS_FAM_A)
         return ns2cyc(`RTS_PULSE_A_NS);
      else
         return ns2cyc(`RTS_ETU_NS);
   endfunction

   // one crc step per data bit, lsb first
   function automatic logic [15:0] crc_bit(input logic [15:0] c,
                                           input logic b);
      return (c >> 1) ^ ((c[0] ^ b) ? `RTS_CRC_POLY : 16'h0000);
   endfunction

   // parity bit appended to a byte
   function automatic logic par(input logic [7:0] d, input logic even);
      return even ? ^d : ~^d;
   endfunction

   // protocol default modulation depth
   function automatic logic [7:0] preset_mod(input logic [7:0] p);
      if (p[4:2] == `RTS_FAM_A)
         return {5'h00, `RTS_DEPTH_OOK};
      else if (p[4:2] == `RTS_FAM_B)
         return {5'h00, `RTS_DEPTH_B};
      else
         return {5'h00, `RTS_DEPTH_V};
   endfunction

   assign f_push = reg_wr && (reg_addr == `RTS_A_FIFO);
   assign f_flush = cmd_valid && (cmd_code == `RTS_C_RESET);

   rts_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .flush(f_flush),
      .in_valid(f_push),
      .in_data(reg_wdata),
      .in_ready(wr_ready),
      .out_valid(f_valid),
      .out_data(f_data),
      .out_ready(f_pop),
      .count(f_cnt)
   );

   // next state of the whole sequencer
   always_comb begin
      n = r;
      f_pop = 1'b0;
      adv = 1'b0;
      sel = 1'b0;
      setb = 8'h00;
      clr = 8'h00;
      fam_a = (r.rg.proto[4:2] == `RTS_FAM_A);
      fam_b = (r.rg.proto[4:2] == `RTS_FAM_B);
      bc = bit_cyc(r.rg.proto, r.rg.hbr);
      pc = pulse_cyc(r.rg.pulse, r.rg.proto);
      bend = (r.bcnt == bc - 16'h0001);
      n.s1 = ext_mod_pin;
      n.s2 = r.s1;
      // register writes; protocol write presets its dependants
      if (reg_wr) begin
         if (reg_addr == `RTS_A_CHIP) begin
            n.rg.chip = reg_wdata;
         end else if (reg_addr == `RTS_A_PROTO) begin
            n.rg.proto = reg_wdata;
            n.rg.typeb = `RTS_PRESET;
            n.rg.hbr = `RTS_PRESET;
            n.rg.pulse = `RTS_PRESET;
            n.rg.modc = preset_mod(reg_wdata);
         end else if (reg_addr == `RTS_A_TYPEB) begin
            n.rg.typeb = reg_wdata;
         end else if (reg_addr == `RTS_A_HBR) begin
            n.rg.hbr = reg_wdata;
         end else if (reg_addr == `RTS_A_PULSE) begin
            n.rg.pulse = reg_wdata;
         end else if (reg_addr == `RTS_A_TMR) begin
            n.rg.tmr = reg_wdata;
         end else if (reg_addr == `RTS_A_MOD) begin
            n.rg.modc = reg_wdata;
         end else if (reg_addr == `RTS_A_RIO) begin
            n.rg.rio = reg_wdata;
         end else if (reg_addr == `RTS_A_LENH) begin
            n.rg.lenh = reg_wdata;
         end else if (reg_addr == `RTS_A_LENL) begin
            n.rg.lenl = reg_wdata;
         end
      end
      // reads; the status register clears on read
      if (reg_rd) begin
         if (reg_addr == `RTS_A_CHIP) n.rdata = r.rg.chip;
         else if (reg_addr == `RTS_A_PROTO) n.rdata = r.rg.proto;
         else if (reg_addr == `RTS_A_TYPEB) n.rdata = r.rg.typeb;
         else if (reg_addr == `RTS_A_HBR) n.rdata = r.rg.hbr;
         else if (reg_addr == `RTS_A_PULSE) n.rdata = r.rg.pulse;
         else if (reg_addr == `RTS_A_TMR) n.rdata = r.rg.tmr;
         else if (reg_addr == `RTS_A_MOD) n.rdata = r.rg.modc;
         else if (reg_addr == `RTS_A_RIO) n.rdata = r.rg.rio;
         else if (reg_addr == `RTS_A_IRQ) begin
            n.rdata = r.rg.irq;
            clr = 8'hff;
         end
         else if (reg_addr == `RTS_A_FCNT) n.rdata = 8'(f_cnt);
         else if (reg_addr == `RTS_A_LENH) n.rdata = r.rg.lenh;
         else if (reg_addr == `RTS_A_LENL) n.rdata = r.rg.lenl;
         else n.rdata = 8'h00; // unmapped and the write-only buffer
      end
      // launch delay runs down in armed state
      if (r.tmr_cnt != 16'h0000) n.tmr_cnt = r.tmr_cnt - 16'h0001;
      // bit timing runs while framing
      if (r.st != rts_pkg::ST_IDLE && r.st != rts_pkg::ST_ARMED)
         n.bcnt = bend ? 16'h0000 : r.bcnt + 16'h0001;
      case (r.st)
         rts_pkg::ST_ARMED: begin
            // wait for delay and for data, or for an empty frame
            if (r.tmr_cnt == 16'h0000 &&
                (f_valid || {r.rg.lenh, r.rg.lenl[7:4]} == 12'h000)) begin
               n.bytes_left = {r.rg.lenh, r.rg.lenl[7:4]};
               n.part = r.rg.lenl[0];
               n.crc_step = (r.rg.lenl[0] || r.rg.proto[`RTS_B_DIRECT])
                            ? 2'd0 : 2'd2;
               n.crc = fam_a ? `RTS_CRC_A : `RTS_CRC_B;
               n.busy = 1'b1;
               n.bcnt = 16'h0000;
               n.st = rts_pkg::ST_SOF;
               if (fam_b && r.rg.typeb[`RTS_B_NOSOF]) begin
                  n.st = rts_pkg::ST_GAP;
                  n.bcnt = bc - 16'h0001;
               end
            end
         end
         rts_pkg::ST_SOF: begin
            if (bend) sel = 1'b1;
         end
         rts_pkg::ST_BITS: begin
            if (bend) begin
               n.sh = r.sh >> 1;
               n.nbits = r.nbits - 4'h1;
               if (r.crc_on && !(r.par_on && r.nbits == 4'h1))
                  n.crc = crc_bit(r.crc, r.sh[0]);
               if (r.nbits == 4'h1) adv = 1'b1;
            end
         end
         rts_pkg::ST_GAP: begin
            if (bend) sel = 1'b1;
         end
         rts_pkg::ST_EOF: begin
            if (bend) begin
               n.st = rts_pkg::ST_IDLE;
               n.busy = 1'b0;
               setb[`RTS_B_TXDONE] = 1'b1;
            end
         end
         default: begin
         end
      endcase
      // a finished unit may earn an extra guard bit
      if (adv) begin
         if (fam_b && r.rg.typeb[`RTS_B_EGT]) n.st = rts_pkg::ST_GAP;
         else sel = 1'b1;
      end
      // choose the next unit: data, partial byte, crc, then eof
      if (sel) begin
         n.st = rts_pkg::ST_BITS;
         n.bcnt = 16'h0000;
         n.par_on = fam_a;
         if (r.bytes_left != 12'h000) begin
            if (f_valid) begin
               f_pop = 1'b1;
               n.bytes_left = r.bytes_left - 12'h001;
               n.sh = {par(f_data, r.rg.hbr[`RTS_B_EVENPAR]), f_data};
               n.nbits = fam_a ? 4'h9 : 4'h8;
               n.crc_on = 1'b1;
            end else begin
               // underrun: hold at the bit boundary until a refill
               n.st = rts_pkg::ST_GAP;
               n.bcnt = r.bcnt;
            end
         end else if (r.part && r.rg.lenl[3:1] != 3'h0) begin
            if (f_valid) begin
               f_pop = 1'b1;
               n.part = 1'b0;
               n.sh = {1'b0, f_data};
               n.nbits = {1'b0, r.rg.lenl[3:1]};
               n.par_on = 1'b0;
               n.crc_on = 1'b0;
            end else begin
               n.st = rts_pkg::ST_GAP;
               n.bcnt = r.bcnt;
            end
         end else if (r.crc_step != 2'd0) begin
            n.part = 1'b0;
            n.crc_step = r.crc_step - 2'd1;
            n.crc = {8'h00, r.crc[15:8]};
            n.sh = {par(r.crc[7:0], r.rg.hbr[`RTS_B_EVENPAR]), r.crc[7:0]};
            n.nbits = fam_a ? 4'h9 : 4'h8;
            n.crc_on = 1'b0;
         end else if (fam_b && r.rg.typeb[`RTS_B_NOEOF]) begin
            n.st = rts_pkg::ST_IDLE;
            n.busy = 1'b0;
            setb[`RTS_B_TXDONE] = 1'b1;
         end else begin
            n.part = 1'b0;
            n.st = rts_pkg::ST_EOF;
         end
      end
      // direct commands; fifo reset also aborts a frame
      if (cmd_valid) begin
         if (cmd_code == `RTS_C_RESET) begin
            n.st = rts_pkg::ST_IDLE;
            n.busy = 1'b0;
         end else if (cmd_code == `RTS_C_TX) begin
            n.st = rts_pkg::ST_ARMED;
            n.tmr_cnt = 16'h0000;
         end else if (cmd_code == `RTS_C_TX_TMR) begin
            n.st = rts_pkg::ST_ARMED;
            n.tmr_cnt = 16'(int'(r.rg.tmr) * int'(ns2cyc(`RTS_TMR_UNIT_NS)));
         end
      end
      // refill request when the buffer runs low mid payload
      lvl = r.busy && (r.bytes_left > 12'(f_cnt)) &&
            (f_cnt <= CW'(LOW_WM));
      n.lvl_prev = lvl;
      if (lvl && !r.lvl_prev) setb[`RTS_B_FLVL] = 1'b1;
      // sticky status, a new event wins over the read clear
      n.rg.irq = (r.rg.irq & ~clr) | setb;
      n.irq_o = (n.rg.irq != 8'h00);
      // pulse: a zero bit, sof and eof modulate for pc clocks
      m = ((r.st == rts_pkg::ST_SOF || r.st == rts_pkg::ST_EOF) ||
           (r.st == rts_pkg::ST_BITS && !r.sh[0])) && (r.bcnt < pc);
      n.mod = m;
      n.ext_mod = m && r.rg.rio[`RTS_B_EXTPA];
      n.rx_ext = r.rg.rio[`RTS_B_EXTPA];
      n.half = !r.rg.chip[`RTS_B_FULLPWR];
      n.depth = r.rg.modc[2:0];
      n.analog = r.rg.modc[`RTS_B_ANALOG];
      if (r.rg.proto[`RTS_B_DIRECT] && r.rg.modc[`RTS_B_EXTMOD])
         n.mod_ook = r.s2;
      else
         n.mod_ook = (r.rg.modc[2:0] == `RTS_DEPTH_OOK);
   end

   // state register; power starts at half
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.half <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign reg_rdata = r.rdata;
   assign mod_out = r.mod;
   assign ext_pa_mod = r.ext_mod;
   assign mod_type_ook = r.mod_ook;
   assign mod_depth = r.depth;
   assign half_power = r.half;
   assign mod_type_analog = r.analog;
   assign rx_ext_subcarrier = r.rx_ext;
   assign irq = r.irq_o;
   assign tx_busy = r.busy;

   // checks; run length of each pulse is counted here
   logic [15:0] mrun;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) mrun <= 16'h0000;
      else mrun <= r.mod ? mrun + 16'h0001 : 16'h0000;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence eof_end_s;
      r.st == rts_pkg::ST_EOF && bend;
   endsequence
   sequence done_s;
      r.st == rts_pkg::ST_IDLE && !r.busy ##1 r.irq_o;
   endsequence

   // config outputs are one flop behind the register bits that drive them; irq sets on the same edge as the status bits
   pwr_sel_a: assert property (
      ##1 half_power == !$past(r.rg.chip[`RTS_B_FULLPWR])
   ) else $error("power level does not follow control bit");
   depth_out_a: assert property (
      ##1 mod_depth == $past(r.rg.modc[2:0])
   ) else $error("modulation depth does not follow field");
   ext_type_a: assert property (
      !(r.rg.proto[`RTS_B_DIRECT] && r.rg.modc[`RTS_B_EXTMOD])
      |=> mod_type_ook == ($past(r.rg.modc[2:0]) == `RTS_DEPTH_OOK)
   ) else $error("pin took modulation type while not enabled");
   proto_preset_a: assert property (
      reg_wr && reg_addr == `RTS_A_PROTO && !cmd_valid
      |=> r.rg.pulse == 8'h00 && r.rg.hbr == 8'h00 && r.rg.typeb == 8'h00
   ) else $error("protocol write did not preset parameters");
   pulse_len_a: assert property (
      $fell(r.mod) && $past(r.st == rts_pkg::ST_BITS, 2) && pc < bc &&
      $stable(r.rg.pulse)
      |-> mrun == pc
   ) else $error("modulation pulse length wrong");
   len_load_a: assert property (
      r.st == rts_pkg::ST_ARMED && $past(r.st) == rts_pkg::ST_ARMED &&
      n.st == rts_pkg::ST_SOF && !cmd_valid
      |=> r.bytes_left == {$past(r.rg.lenh), $past(r.rg.lenl[7:4])}
   ) else $error("byte count not taken from length registers");
   first_byte_a: assert property (
      r.st == rts_pkg::ST_ARMED && r.tmr_cnt == 16'h0000 && f_valid &&
      !cmd_valid |=> r.busy
   ) else $error("did not start on first buffered byte");
   tx_done_a: assert property (
      eof_end_s ##0 !cmd_valid |=> done_s
   ) else $error("no done flag and irq after frame end");
   stop_exact_a: assert property (
      r.st == rts_pkg::ST_EOF |-> r.bytes_left == 12'h000 &&
      r.crc_step == 2'd0 && !r.part
   ) else $error("end of frame before payload was sent");
endmodule

// File: sim/rts_host_model.sv
// host model: register writes, reads and direct commands
// assumes the sequencer samples its strobes on the rising clock edge
`timescale 1ns/1ns
`include "rts_defines.svh"
module rts_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [4:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic cmd_valid,
   output logic [7:0] cmd_code
);
   // bus idle from time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cmd_valid = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      cmd_code = 8'h00;
   end
   // one write, strobe high for exactly one sampling edge
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d; // released data never keeps its old value
   endtask
   // one read; data is taken a full edge after the strobe
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      #1 d = reg_rdata;
   endtask
   // one direct command pulse
   task automatic cmd(input logic [7:0] c);
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
   endtask
   // buffer is cleared before every frame
   task automatic clr();
      cmd(`RTS_C_RESET);
   endtask
endmodule

// File: sim/tb.sv
// bench for the transmit sequencer: config pins, framing, start methods
// assumes the host model drives the register and command ports
`timescale 1ns/1ns
`include "rts_defines.svh"
module tb;
   logic ref_clk, rst_b, ext_mod_pin;
   logic reg_wr, reg_rd, cmd_valid, wr_ready, mod_out, ext_pa_mod;
   logic mod_type_ook, half_power, mod_type_analog, rx_ext, irq, tx_busy;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, cmd_code, reg_rdata, rv;
   logic [2:0] mod_depth;
   int n_fail, checked, cyc;
   rts_tx_seq i_rts_tx_seq (.ref_clk(ref_clk), .rst_b(rst_b),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .ext_mod_pin(ext_mod_pin), .reg_rdata(reg_rdata),
      .wr_ready(wr_ready), .mod_out(mod_out), .ext_pa_mod(ext_pa_mod),
      .mod_type_ook(mod_type_ook), .mod_depth(mod_depth),
      .half_power(half_power), .mod_type_analog(mod_type_analog),
      .rx_ext_subcarrier(rx_ext), .irq(irq), .tx_busy(tx_busy));
   rts_host_model h (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code));
   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // hang guard, well above the longest frame
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [15:0] s, e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // wait for tx_busy to reach a level, bounded
   task automatic wbusy(input logic v, input int lim);
      int i;
      i = 0;
      #1; // look only once the edge has settled
      while (tx_busy !== v && i < lim) begin
         @(posedge ref_clk);
         #1 i++;
      end
      chk("tx_busy", tx_busy, v);
   endtask
   task automatic end_sim();
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // static config pins follow their register bits
   task automatic t_cfg();
      chk("half_rst", half_power, 1'b1);
      h.wr(`RTS_A_CHIP, 8'h10);
      h.wr(`RTS_A_MOD, 8'h4d);
      h.wr(`RTS_A_RIO, 8'h40);
      repeat (2) @(posedge ref_clk);
      #1 chk("half", half_power, 1'b0);
      chk("depth", mod_depth, 3'h5);
      chk("analog", mod_type_analog, 1'b1);
      chk("rx_ext", rx_ext, 1'b1);
      h.wr(`RTS_A_LENH, 8'h12);
      h.rd(`RTS_A_LENH, rv);
      chk("lenh", rv, 8'h12);
      h.rd(`RTS_A_FIFO, rv);
      chk("fifo_rd", rv, 8'h00);
   endtask
   // protocol write presets pulse length and depth
   task automatic t_preset();
      h.wr(`RTS_A_PULSE, 8'h33);
      h.wr(`RTS_A_PROTO, 8'h0b);
      h.rd(`RTS_A_PULSE, rv);
      chk("preset_pulse", rv, 8'h00);
      chk("preset_depth", mod_depth, `RTS_DEPTH_OOK);
      chk("ook", mod_type_ook, 1'b1);
      // direct mode with the pin enabled: the type follows the pin
      h.wr(`RTS_A_PROTO, 8'h4b);
      h.wr(`RTS_A_MOD, 8'h47);
      repeat (4) @(posedge ref_clk);
      #1 chk("pin_ook0", mod_type_ook, 1'b0);
      @(posedge ref_clk);
      ext_mod_pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 chk("pin_ook1", mod_type_ook, 1'b1);
      h.wr(`RTS_A_PROTO, 8'h0b);
   endtask
   // start by command after data; pulse width and completion
   task automatic t_cmd_first_data();
      int n;
      h.wr(`RTS_A_PULSE, 8'h05);
      h.wr(`RTS_A_LENH, 8'h00);
      h.wr(`RTS_A_LENL, 8'h10);
      h.clr();
      h.wr(`RTS_A_FIFO, 8'ha5);
      h.cmd(`RTS_C_TX);
      wbusy(1'b1, 4);
      n = 0;
      while (mod_out !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         #1 n++;
      end
      chk("ext_pa", ext_pa_mod, 1'b1);
      n = 0;
      while (mod_out === 1'b1 && n < 200) begin
         @(posedge ref_clk);
         #1 n++;
      end
      chk("pulse_len", n, (5 * 737 + 99) / 100);
      wbusy(1'b0, 5000);
      chk("mod_idle", mod_out, 1'b0);
      repeat (2) @(posedge ref_clk);
      #1 chk("irq_done", irq, 1'b1);
      h.rd(`RTS_A_IRQ, rv);
      chk("status", rv, 8'h80);
      chk("irq_clr", irq, 1'b0);
   endtask
   // command and length first, frame starts on first byte
   task automatic t_data_after_cmd();
      h.clr();
      h.cmd(`RTS_C_TX);
      repeat (6) @(posedge ref_clk);
      #1 chk("armed_idle", tx_busy, 1'b0);
      h.wr(`RTS_A_FIFO, 8'h3c);
      wbusy(1'b1, 3);
      wbusy(1'b0, 5000);
      h.rd(`RTS_A_IRQ, rv);
      chk("done2", rv, 8'h80);
   endtask
   // timed start with a trailing partial byte
   task automatic t_timer();
      h.wr(`RTS_A_LENL, 8'h17);
      h.wr(`RTS_A_TMR, 8'h01);
      h.clr();
      h.wr(`RTS_A_FIFO, 8'h5a);
      h.wr(`RTS_A_FIFO, 8'h05);
      h.cmd(`RTS_C_TX_TMR);
      // one 1 us step is 100 clocks, then the start edge
      repeat (100) @(posedge ref_clk);
      #1 chk("tmr_wait", tx_busy, 1'b0);
      @(posedge ref_clk);
      #1 chk("tmr_go", tx_busy, 1'b1);
      wbusy(1'b0, 5000);
      h.rd(`RTS_A_IRQ, rv);
      chk("done_tmr", rv, 8'h80);
      h.rd(`RTS_A_FCNT, rv);
      chk("part_used", rv, 8'h00);
   endtask
   // payload longer than the buffer, refilled on level flag
   task automatic t_refill();
      int i;
      h.wr(`RTS_A_LENL, 8'ha0);
      h.clr();
      for (i = 0; i < 8; i++) begin
         #1 chk("space", wr_ready, 1'b1);
         h.wr(`RTS_A_FIFO, i[7:0]);
      end
      @(posedge ref_clk);
      #1 chk("full", wr_ready, 1'b0);
      h.cmd(`RTS_C_TX);
      i = 0;
      while (irq !== 1'b1 && i < 12000) begin
         @(posedge ref_clk);
         #1 i++;
      end
      h.rd(`RTS_A_IRQ, rv);
      chk("lvl_flag", rv, 8'h20);
      h.wr(`RTS_A_FIFO, 8'h08);
      h.wr(`RTS_A_FIFO, 8'h09);
      wbusy(1'b0, 15000);
      h.rd(`RTS_A_IRQ, rv);
      chk("done_long", rv, 8'h80);
   endtask
   // main sequence
   initial begin
      n_fail = 0;
      checked = 0;
      cyc = 0;
      ext_mod_pin = 1'b0;
      rst_b = 1'b0;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      #1 chk("busy_rst", tx_busy, 1'b0);
      t_cfg();
      t_preset();
      t_cmd_first_data();
      t_data_after_cmd();
      t_timer();
      t_refill();
      end_sim();
   end
endmodule
